// ===== core/dtf_pkg.sv
package dtf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register select codes on the three address pins
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_FAULT = 3'h1;
	localparam logic [2:0] A_COUNT = 3'h2;
	localparam logic [2:0] A_SECTOR = 3'h3;
	localparam logic [2:0] A_CYL_LO = 3'h4;
	localparam logic [2:0] A_CYL_HI = 3'h5;
	localparam logic [2:0] A_SELECT = 3'h6;
	localparam logic [2:0] A_STATE = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Status byte fields
	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_WFAULT = 5;
	localparam int ST_SEEKDONE = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;

	// Fault detail fields
	localparam int ER_BADBLK = 7;
	localparam int ER_DATACRC = 6;
	localparam int ER_IDCRC = 5;
	localparam int ER_NOHDR = 4;
	localparam int ER_ABORT = 2;
	localparam int ER_TRK0 = 1;
	localparam int ER_NODAM = 0;

	// Drive number field in the select register
	localparam int SEL_DRIVE_LSB = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Command opcodes, upper nibble of the command byte
	localparam logic [3:0] CMD_RESTORE = 4'h1;
	localparam logic [3:0] CMD_READ = 4'h2;
	localparam logic [3:0] CMD_WRITE = 4'h3;
	localparam logic [3:0] CMD_FORMAT = 4'h5;

	////////////////////////////////////////////////////////////////////////////////
	// Counts and timing
	localparam logic [4:0] DAM_WINDOW_BYTES = 5'h10;
	localparam logic [9:0] RECAL_MAX_STEPS = 10'h3FF;
	localparam int PRECOMP_SHIFT_NS = 10;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PRECOMP_CYC = (PRECOMP_SHIFT_NS / CLK_PERIOD_NS < 1) ? 1 : PRECOMP_SHIFT_NS / CLK_PERIOD_NS;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Sector buffer ownership, Gray from idle through fill to drain; drain back to idle changes two bits
	typedef enum logic [2:0] {
		DTF_IDLE = 3'h0,
		DTF_HOST_FILL = 3'h1,
		DTF_DISK_DRAIN = 3'h3,
		DTF_DISK_FILL = 3'h2,
		DTF_HOST_DRAIN = 3'h6
	} dtf_mode_t;

endpackage : dtf_pkg

// ===== core/dtf_task_file.sv
// Operation
// - Ten-bit cylinder per drive from two registers
// - Sector number register readable and writable
// - Format counts sector count down to zero
// - Fault detail read-only, valid with error bit
// - Threshold times four enables precomp and current
// - Precomp shifts write data by fixed 10 ns
// - Each data access moves one buffer byte
// - Request line while buffer awaits host
// - Status byte layout busy ready fault seek request error
// - Fault detail byte layout
// - Error bit follows faults, cleared on command
// - Request bit mirrors line, drops when done
// - Drive status bits track selected drive lines
// - No command runs with fault or not ready
// - Busy set when command issued
// - Missing data mark after 16 bytes
// - Track-zero error after 1023 steps
// - Aborted bit when drive status blocks command
// - Header missing flag when no ID matches
// - ID and data checksum error bits
// - Bad block mark sets bit, skips data
// - Status access clears interrupt line
module dtf_task_file import dtf_pkg::*; #(
	parameter int SECTOR_BYTES = 256,
	parameter int NUM_DRIVES = 4
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic re_n_i,
	input wire logic we_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	output logic host_interrupt_line_o,
	output logic buffer_request_line_o,
	input wire logic ready_i,
	input wire logic write_fault_i,
	input wire logic seek_complete_i,
	input wire logic track_zero_indicator_i,
	output logic [1:0] drive_select_o,
	output logic inner_zone_write_current_o,
	input wire logic write_data_i,
	output logic write_data_o,
	output logic cmd_start_o,
	output logic [7:0] cmd_code_o,
	output logic [9:0] target_cylinder_o,
	output logic [7:0] target_sector_o,
	input wire logic cmd_done_i,
	input wire logic format_sector_done_i,
	input wire logic id_found_i,
	input wire logic read_byte_tick_i,
	input wire logic data_address_mark_i,
	input wire logic step_pulse_i,
	input wire logic id_crc_error_i,
	input wire logic data_crc_error_i,
	input wire logic header_missing_flag_i,
	input wire logic bad_block_i,
	output logic data_field_skip_o,
	input wire logic [7:0] disk_data_i,
	input wire logic disk_valid_i,
	output logic disk_ready_o,
	output logic [7:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);

	localparam int PTRW = $clog2(SECTOR_BYTES);
	localparam int DRVW = (NUM_DRIVES > 1) ? $clog2(NUM_DRIVES) : 1;
	localparam logic [PTRW-1:0] PTR_LAST = PTRW'(SECTOR_BYTES - 1);

	typedef struct packed {
		logic [1:0] cs_n;
		logic [1:0] re_n;
		logic [1:0] we_n;
		logic [1:0][2:0] addr;
		logic [1:0][7:0] data;
		logic [1:0][3:0] drv;
		logic re_prev;
		logic we_prev;
		logic [NUM_DRIVES-1:0][7:0] cyl_lo;
		logic [NUM_DRIVES-1:0][7:0] cyl_hi;
		logic [7:0] sector;
		logic [7:0] count;
		logic [7:0] precomp;
		logic [7:0] select;
		logic [7:0] fault;
		logic err;
		logic busy;
		logic irq;
		logic [7:0] dout;
		logic oe;
		dtf_mode_t mode;
		logic [PTRW-1:0] ptr;
		logic [1:0][7:0] f_data;
		logic [1:0] f_cnt;
		logic f_rd;
		logic f_wr;
		logic [7:0] cmd;
		logic start;
		logic is_read;
		logic dam_arm;
		logic [4:0] dam_cnt;
		logic recal;
		logic [9:0] steps;
		logic inner_zone_write_current;
		logic [PRECOMP_CYC-1:0] wd;
		logic wr_out;
	} dtf_state_t;

	dtf_state_t state_ff;
	dtf_state_t nxt_state;
	logic [7:0] buf_mem [SECTOR_BYTES];
	logic buf_we;
	logic [7:0] buf_wdata;
	logic [7:0] buf_rdata;

	function automatic logic [9:0] dtf_cyl(input logic [7:0] lo, input logic [7:0] hi);
		dtf_cyl = {hi[1:0], lo};
	endfunction : dtf_cyl

	assign buf_rdata = buf_mem[state_ff.ptr];

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [DRVW-1:0] d;
		logic [2:0] a;
		logic [7:0] wd;
		logic [9:0] cyl;
		logic ready, wfault, seekdone, trk0, rd, wr, push, pop, buffer_request_line;
		d = '0;
		{a, wd, cyl} = 21'h000000;
		{ready, wfault, seekdone, trk0, rd, wr, push, pop, buffer_request_line} = 9'h000;
		nxt_state = state_ff;
		buf_we = 1'b0;
		buf_wdata = '0;
		nxt_state.start = 1'b0;
		// Two-flop synchronisers on the host bus pins and the four drive status inputs
		nxt_state.cs_n = {state_ff.cs_n[0], cs_n_i};
		nxt_state.re_n = {state_ff.re_n[0], re_n_i};
		nxt_state.we_n = {state_ff.we_n[0], we_n_i};
		nxt_state.addr = {state_ff.addr[0], addr_i};
		nxt_state.data = {state_ff.data[0], data_i};
		nxt_state.drv = {state_ff.drv[0], {ready_i, write_fault_i, seek_complete_i, track_zero_indicator_i}};
		nxt_state.re_prev = state_ff.re_n[1];
		nxt_state.we_prev = state_ff.we_n[1];
		// Live drive lines of the selected drive
		{ready, wfault, seekdone, trk0} = state_ff.drv[1];
		d = state_ff.select[SEL_DRIVE_LSB +: DRVW];
		a = state_ff.addr[1];
		wd = state_ff.data[1];
		rd = !state_ff.cs_n[1] && !state_ff.re_n[1] && state_ff.re_prev;
		wr = !state_ff.cs_n[1] && !state_ff.we_n[1] && state_ff.we_prev;
		buffer_request_line = (state_ff.mode == DTF_HOST_FILL) || (state_ff.mode == DTF_HOST_DRAIN);
		nxt_state.oe = !state_ff.cs_n[1] && !state_ff.re_n[1];
		////////////////////////////////////////////////////////////////////////////
		// Host reads
		if (rd) begin
			case (a)
				A_DATA: begin
					nxt_state.dout = buf_rdata;
					if (state_ff.mode == DTF_HOST_DRAIN) begin
						nxt_state.ptr = state_ff.ptr + 1'b1;
						if (state_ff.ptr == PTR_LAST) begin
							nxt_state.mode = DTF_IDLE;
						end
					end
				end
				A_FAULT: nxt_state.dout = state_ff.fault;
				A_COUNT: nxt_state.dout = state_ff.count;
				A_SECTOR: nxt_state.dout = state_ff.sector;
				A_CYL_LO: nxt_state.dout = state_ff.cyl_lo[d];
				A_CYL_HI: nxt_state.dout = state_ff.cyl_hi[d];
				A_SELECT: nxt_state.dout = state_ff.select;
				A_STATE: begin
					nxt_state.dout = RST_BYTE;
					nxt_state.dout[ST_BUSY] = state_ff.busy;
					nxt_state.dout[ST_READY] = ready;
					nxt_state.dout[ST_WFAULT] = wfault;
					nxt_state.dout[ST_SEEKDONE] = seekdone;
					nxt_state.dout[ST_DRQ] = buffer_request_line;
					nxt_state.dout[ST_ERR] = state_ff.err;
					nxt_state.irq = 1'b0;
				end
				default: nxt_state.dout = RST_BYTE;
			endcase
		end
		////////////////////////////////////////////////////////////////////////////
		// Host writes
		if (wr) begin
			case (a)
				A_DATA: begin
					if (state_ff.mode == DTF_HOST_FILL) begin
						buf_we = 1'b1;
						buf_wdata = wd;
						nxt_state.ptr = state_ff.ptr + 1'b1;
						if (state_ff.ptr == PTR_LAST) begin
							nxt_state.mode = DTF_DISK_DRAIN;
							nxt_state.ptr = '0;
						end
					end
				end
				A_FAULT: nxt_state.precomp = wd;
				A_COUNT: nxt_state.count = wd;
				A_SECTOR: nxt_state.sector = wd;
				A_CYL_LO: nxt_state.cyl_lo[d] = wd;
				A_CYL_HI: nxt_state.cyl_hi[d] = wd;
				A_SELECT: nxt_state.select = wd;
				A_STATE: begin
					// Commands are ignored while a previous one runs
					if (!state_ff.busy) begin
						// New command clears the error bit
						nxt_state.err = 1'b0;
						nxt_state.fault = RST_BYTE;
						nxt_state.irq = 1'b0;
						nxt_state.cmd = wd;
						nxt_state.ptr = '0;
						nxt_state.dam_arm = 1'b0;
						nxt_state.recal = 1'b0;
						if (wfault || !ready) begin
							nxt_state.fault[ER_ABORT] = 1'b1;
							nxt_state.irq = 1'b1;
							nxt_state.mode = DTF_IDLE;
						end else begin
							nxt_state.busy = 1'b1;
							nxt_state.start = 1'b1;
							nxt_state.is_read = (wd[7:4] == CMD_READ);
							nxt_state.recal = (wd[7:4] == CMD_RESTORE);
							nxt_state.steps = '0;
							case (wd[7:4])
								CMD_READ: nxt_state.mode = DTF_DISK_FILL;
								CMD_WRITE: nxt_state.mode = DTF_HOST_FILL;
								CMD_FORMAT: nxt_state.mode = DTF_HOST_FILL;
								default: nxt_state.mode = DTF_IDLE;
							endcase
						end
					end
				end
				default: ;
			endcase
		end
		////////////////////////////////////////////////////////////////////////////
		// Disk side of the sector buffer
		if (state_ff.mode == DTF_DISK_FILL && disk_valid_i) begin
			buf_we = 1'b1;
			buf_wdata = disk_data_i;
			nxt_state.ptr = state_ff.ptr + 1'b1;
			if (state_ff.ptr == PTR_LAST) begin
				nxt_state.mode = DTF_HOST_DRAIN;
				nxt_state.ptr = '0;
			end
		end
		// Two-entry buffer toward the disk writer
		pop = out_ready_i && (state_ff.f_cnt != 2'h0);
		push = (state_ff.mode == DTF_DISK_DRAIN) && (state_ff.f_cnt != 2'h2);
		if (pop) begin
			nxt_state.f_rd = !state_ff.f_rd;
		end
		if (push) begin
			nxt_state.f_data[state_ff.f_wr] = buf_rdata;
			nxt_state.f_wr = !state_ff.f_wr;
			nxt_state.ptr = state_ff.ptr + 1'b1;
			if (state_ff.ptr == PTR_LAST) begin
				nxt_state.mode = DTF_IDLE;
			end
		end
		nxt_state.f_cnt = state_ff.f_cnt + {1'b0, push} - {1'b0, pop};
		////////////////////////////////////////////////////////////////////////////
		// Sequencer events; sets come after clears so they win, except that command done clears dam_arm after an ID match sets it
		// Format countdown stops at zero
		if (format_sector_done_i && state_ff.count != RST_BYTE) begin
			nxt_state.count = state_ff.count - 8'h01;
		end
		if (state_ff.is_read && state_ff.busy && id_found_i) begin
			nxt_state.dam_arm = 1'b1;
			nxt_state.dam_cnt = '0;
		end else if (state_ff.dam_arm) begin
			if (data_address_mark_i) begin
				nxt_state.dam_arm = 1'b0;
			end else if (read_byte_tick_i) begin
				nxt_state.dam_cnt = state_ff.dam_cnt + 5'h01;
				if (state_ff.dam_cnt + 5'h01 == DAM_WINDOW_BYTES) begin
					nxt_state.fault[ER_NODAM] = 1'b1;
					nxt_state.dam_arm = 1'b0;
				end
			end
		end
		if (state_ff.recal) begin
			if (trk0) begin
				nxt_state.recal = 1'b0;
			end else if (step_pulse_i) begin
				nxt_state.steps = state_ff.steps + 10'h001;
				if (state_ff.steps + 10'h001 == RECAL_MAX_STEPS) begin
					nxt_state.fault[ER_TRK0] = 1'b1;
					nxt_state.recal = 1'b0;
				end
			end
		end
		// Each fault sets its own detail bit, the data checksum fault only from the start of a read command until another command starts
		nxt_state.fault[ER_IDCRC] = nxt_state.fault[ER_IDCRC] | id_crc_error_i;
		nxt_state.fault[ER_DATACRC] = nxt_state.fault[ER_DATACRC] | (data_crc_error_i && state_ff.is_read);
		nxt_state.fault[ER_NOHDR] = nxt_state.fault[ER_NOHDR] | header_missing_flag_i;
		// Bad block skips the data field
		if (bad_block_i) begin
			nxt_state.fault[ER_BADBLK] = 1'b1;
			if (state_ff.mode == DTF_DISK_DRAIN || state_ff.mode == DTF_DISK_FILL) begin
				nxt_state.mode = DTF_IDLE;
			end
		end
		if (cmd_done_i && state_ff.busy) begin
			nxt_state.busy = 1'b0;
			nxt_state.irq = 1'b1;
			nxt_state.recal = 1'b0;
			nxt_state.dam_arm = 1'b0;
		end
		// Error bit whenever any fault bit is set
		if (|nxt_state.fault) begin
			nxt_state.err = 1'b1;
		end
		////////////////////////////////////////////////////////////////////////////
		// Write precompensation
		// Compare against threshold times four
		cyl = dtf_cyl(state_ff.cyl_lo[d], state_ff.cyl_hi[d]);
		nxt_state.inner_zone_write_current = (cyl >= {state_ff.precomp, 2'b00});
		nxt_state.wd = PRECOMP_CYC'({state_ff.wd, write_data_i});
		nxt_state.wr_out = state_ff.inner_zone_write_current ? state_ff.wd[PRECOMP_CYC-1] : write_data_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= '0;
			state_ff.cs_n <= 2'h3;
			state_ff.re_n <= 2'h3;
			state_ff.we_n <= 2'h3;
			state_ff.re_prev <= 1'b1;
			state_ff.we_prev <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (buf_we) begin
			buf_mem[state_ff.ptr] <= buf_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign data_o = state_ff.dout;
	assign data_oe_o = state_ff.oe;
	assign host_interrupt_line_o = state_ff.irq;
	// Request while buffer waits on host
	assign buffer_request_line_o = (state_ff.mode == DTF_HOST_FILL) || (state_ff.mode == DTF_HOST_DRAIN);
	assign drive_select_o = state_ff.select[SEL_DRIVE_LSB +: 2];
	assign inner_zone_write_current_o = state_ff.inner_zone_write_current;
	assign write_data_o = state_ff.wr_out;
	assign cmd_start_o = state_ff.start;
	assign cmd_code_o = state_ff.cmd;
	assign target_cylinder_o = dtf_cyl(state_ff.cyl_lo[state_ff.select[SEL_DRIVE_LSB +: DRVW]],
		state_ff.cyl_hi[state_ff.select[SEL_DRIVE_LSB +: DRVW]]);
	assign target_sector_o = state_ff.sector;
	assign data_field_skip_o = state_ff.fault[ER_BADBLK];
	assign disk_ready_o = (state_ff.mode == DTF_DISK_FILL);
	assign out_data_o = state_ff.f_data[state_ff.f_rd];
	assign out_valid_o = (state_ff.f_cnt != 2'h0);

endmodule : dtf_task_file

// ===== dv/dtf_drive_model.sv
module dtf_drive_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic fill_i,
	input wire logic slow_i,
	input wire logic disk_ready_i,
	input wire logic out_valid_i,
	input wire logic [7:0] out_data_i,
	output logic [7:0] disk_data_o,
	output logic disk_valid_o,
	output logic out_ready_o,
	output logic write_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sent;
	logic [3:0] ph;
	logic [7:0] rx [0:31];
	int nrx;

	////////////////////////////////////////////////////////////////////////////////
	// one byte per handshake
	assign disk_valid_o = fill_i;
	assign disk_data_o = fill_i ? 8'hC0 + sent : ~(8'hC0 + sent);
	// Slow mode accepts one word in four
	assign out_ready_o = !slow_i || ph[1:0] == 2'h0;
	assign write_data_o = ph[0] ^ ph[2];
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sent <= 8'h00;
			ph <= 4'h0;
			nrx <= 0;
		end else begin
			ph <= ph + 4'h1;
			if (disk_valid_o && disk_ready_i) begin
				sent <= sent + 8'h01;
			end
			if (out_valid_i && out_ready_o) begin
				rx[nrx[4:0]] <= out_data_i;
				nrx <= nrx + 1;
			end
		end
	end
endmodule : dtf_drive_model

// ===== dv/dtf_task_file_monitor.sv
module dtf_task_file_monitor import dtf_pkg::*; (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic re_n_i,
	input wire logic [2:0] addr_i,
	input wire logic host_interrupt_line_o,
	input wire logic buffer_request_line_o,
	input wire logic ready_i,
	input wire logic write_fault_i,
	input wire logic inner_zone_write_current_o,
	input wire logic write_data_i,
	input wire logic write_data_o,
	input wire logic cmd_start_o,
	input wire logic [7:0] cmd_code_o,
	input wire logic bad_block_i,
	input wire logic data_field_skip_o,
	input wire logic disk_ready_o,
	input wire logic [7:0] out_data_o,
	input wire logic out_valid_o,
	input wire logic out_ready_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	sequence status_read_s;
		(!cs_n_i && !re_n_i && addr_i == A_STATE) [*5];
	endsequence
	sequence drive_blocked_s;
		(write_fault_i || !ready_i) [*6];
	endsequence

	AST_IRQ_CLEAR: assert property (status_read_s |-> !host_interrupt_line_o)
		else $error("interrupt high during status read");
	AST_NO_START_BLOCKED: assert property (drive_blocked_s |-> !cmd_start_o)
		else $error("command started with drive blocked");
	AST_START_PULSE: assert property (cmd_start_o |=> !cmd_start_o)
		else $error("start pulse longer than one cycle");
	AST_WRITE_REQ: assert property (cmd_start_o && cmd_code_o[7:4] == CMD_WRITE |-> buffer_request_line_o)
		else $error("no request at write start");
	AST_READ_FILL: assert property (cmd_start_o && cmd_code_o[7:4] == CMD_READ |-> disk_ready_o)
		else $error("read start without buffer fill");
	AST_FILL_NO_REQ: assert property (disk_ready_o |-> !buffer_request_line_o)
		else $error("request high while buffer filling");
	AST_SKIP: assert property (bad_block_i |-> ##[1:3] data_field_skip_o)
		else $error("bad block did not skip data field");
	AST_PRECOMP_ON: assert property (inner_zone_write_current_o [*4] |-> write_data_o == $past(write_data_i, 2))
		else $error("write data not shifted in inner zone");
	AST_PRECOMP_OFF: assert property (!inner_zone_write_current_o [*4] |-> write_data_o == $past(write_data_i))
		else $error("write data shifted outside inner zone");
	AST_OUT_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
		else $error("output word lost during stall");
endmodule : dtf_task_file_monitor

bind dtf_task_file dtf_task_file_monitor mon_u (.mclk_i, .rst_i, .cs_n_i, .re_n_i, .addr_i, .host_interrupt_line_o,
	.buffer_request_line_o, .ready_i, .write_fault_i, .inner_zone_write_current_o, .write_data_i, .write_data_o,
	.cmd_start_o, .cmd_code_o, .bad_block_i, .data_field_skip_o, .disk_ready_o, .out_data_o, .out_valid_o, .out_ready_i);

// ===== dv/dtf_task_file_tb_top.sv
module dtf_task_file_tb_top import dtf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NB = 8;
	logic mclk_i, rst_i, cs_n_i, re_n_i, we_n_i, ready_i, write_fault_i, seek_complete_i, track_zero_indicator_i;
	logic data_oe_o, host_interrupt_line_o, buffer_request_line_o, inner_zone_write_current_o, write_data_i;
	logic write_data_o, cmd_start_o, data_field_skip_o, disk_valid_i, disk_ready_o, out_valid_o, out_ready_i;
	logic fill, slow, ro;
	logic [9:0] pv, target_cylinder_o;
	logic [2:0] addr_i;
	logic [1:0] drive_select_o;
	logic [7:0] data_i, data_o, cmd_code_o, target_sector_o, disk_data_i, out_data_o, rv;
	int n_mismatch, compares, cyc, k;

	dtf_task_file #(.SECTOR_BYTES(NB), .NUM_DRIVES(4)) dut_u (.mclk_i, .rst_i, .cs_n_i, .re_n_i, .we_n_i, .addr_i,
		.data_i, .data_o, .data_oe_o, .host_interrupt_line_o, .buffer_request_line_o, .ready_i, .write_fault_i,
		.seek_complete_i, .track_zero_indicator_i, .drive_select_o, .inner_zone_write_current_o, .write_data_i,
		.write_data_o, .cmd_start_o, .cmd_code_o, .target_cylinder_o, .target_sector_o, .cmd_done_i(pv[0]),
		.format_sector_done_i(pv[1]), .id_found_i(pv[2]), .read_byte_tick_i(pv[3]), .data_address_mark_i(pv[4]),
		.step_pulse_i(pv[5]), .id_crc_error_i(pv[6]), .data_crc_error_i(pv[7]), .header_missing_flag_i(pv[8]),
		.bad_block_i(pv[9]), .data_field_skip_o, .disk_data_i, .disk_valid_i, .disk_ready_o, .out_data_o,
		.out_valid_o, .out_ready_i);
	dtf_drive_model drv_u (.mclk_i, .rst_i, .fill_i(fill), .slow_i(slow), .disk_ready_i(disk_ready_o),
		.out_valid_i(out_valid_o), .out_data_i(out_data_o), .disk_data_o(disk_data_i), .disk_valid_o(disk_valid_i),
		.out_ready_o(out_ready_i), .write_data_o(write_data_i));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		addr_i = a;
		data_i = d;
		cs_n_i = 1'b0;
		we_n_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		cs_n_i = 1'b1;
		we_n_i = 1'b1;
		repeat (4) @(negedge mclk_i);
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(negedge mclk_i);
		addr_i = a;
		cs_n_i = 1'b0;
		re_n_i = 1'b0;
		repeat (5) @(negedge mclk_i);
		rv = data_o;
		ro = data_oe_o;
		cs_n_i = 1'b1;
		re_n_i = 1'b1;
		repeat (4) @(negedge mclk_i);
	endtask : rd
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk(nm, {9'h000, e}, {9'h000, g});
	endtask : chk_bit
	task automatic chk_reg(input string nm, input logic [2:0] a, input logic [7:0] e);
		rd(a);
		chk(nm, {2'h0, e}, {2'h0, rv});
		chk_bit("output enable", 1'b1, ro);
	endtask : chk_reg
	task automatic pulse(input logic [9:0] m, input int n);
		repeat (n) begin
			@(negedge mclk_i);
			pv = m;
			@(negedge mclk_i);
			pv = 10'h000;
		end
	endtask : pulse
	task automatic wait_out(input int n);
		for (k = 0; k < 400 && drv_u.nrx < n; k++) @(negedge mclk_i);
	endtask : wait_out
	task automatic final_report;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{cs_n_i, re_n_i, we_n_i, ready_i, seek_complete_i, rst_i} = 6'h3F;
		{write_fault_i, track_zero_indicator_i, fill, slow} = 4'h0;
		{pv, addr_i, data_i} = 21'h000000;
		{n_mismatch, compares, cyc} = 0;
		repeat (6) @(negedge mclk_i);
		rst_i = 1'b0;
		chk_reg("status", A_STATE, 8'h50);
		chk_reg("count", A_COUNT, 8'h00);
		$display("reset test done");
		wr(A_SELECT, 8'h08);
		wr(A_CYL_LO, 8'h11);
		wr(A_CYL_HI, 8'h01);
		chk("drive", 10'h001, {8'h00, drive_select_o});
		chk("cylinder", 10'h111, target_cylinder_o);
		wr(A_SELECT, 8'h00);
		wr(A_CYL_LO, 8'h34);
		wr(A_CYL_HI, 8'hFE);
		chk("cylinder", 10'h234, target_cylinder_o);
		chk_reg("cyl high", A_CYL_HI, 8'hFE);
		wr(A_SELECT, 8'h08);
		chk("cylinder", 10'h111, target_cylinder_o);
		wr(A_SELECT, 8'h00);
		wr(A_SECTOR, 8'hA5);
		chk_reg("sector", A_SECTOR, 8'hA5);
		chk("sector out", 10'h0A5, {2'h0, target_sector_o});
		$display("register test done");
		wr(A_FAULT, 8'h20);
		chk_bit("zone", 1'b1, inner_zone_write_current_o);
		chk_reg("fault", A_FAULT, 8'h00);
		wr(A_CYL_LO, 8'h7F);
		wr(A_CYL_HI, 8'h00);
		chk_bit("zone", 1'b0, inner_zone_write_current_o);
		wr(A_CYL_LO, 8'h80);
		chk_bit("zone", 1'b1, inner_zone_write_current_o);
		$display("precomp test done");
		write_fault_i = 1'b1;
		wr(A_STATE, 8'h30);
		chk_bit("irq", 1'b1, host_interrupt_line_o);
		chk_reg("fault", A_FAULT, 8'h04);
		chk_reg("status", A_STATE, 8'h71);
		chk_bit("irq", 1'b0, host_interrupt_line_o);
		$display("abort test done");
		write_fault_i = 1'b0;
		slow = 1'b1;
		wr(A_STATE, 8'h30);
		chk_reg("status", A_STATE, 8'hD8);
		chk("command", 10'h030, {2'h0, cmd_code_o});
		for (int i = 0; i < NB; i++) wr(A_DATA, 8'h60 | 8'(i));
		chk_bit("request", 1'b0, buffer_request_line_o);
		wait_out(NB);
		for (int i = 0; i < NB; i++) chk("out byte", {2'h0, 8'h60 | 8'(i)}, {2'h0, drv_u.rx[i]});
		pulse(10'h001, 1);
		chk_reg("status", A_STATE, 8'h50);
		$display("write test done");
		fill = 1'b1;
		wr(A_STATE, 8'h20);
		for (k = 0; k < 400 && buffer_request_line_o !== 1'b1; k++) @(negedge mclk_i);
		fill = 1'b0;
		for (int i = 0; i < NB; i++) chk_reg("in byte", A_DATA, 8'hC0 | 8'(i));
		chk_bit("request", 1'b0, buffer_request_line_o);
		pulse(10'h004, 1);
		pulse(10'h008, 16);
		pulse(10'h1C0, 1);
		pulse(10'h001, 1);
		chk_reg("fault", A_FAULT, 8'h71);
		chk_reg("status", A_STATE, 8'h51);
		$display("read test done");
		wr(A_COUNT, 8'h03);
		wr(A_STATE, 8'h50);
		for (int i = 0; i < NB; i++) wr(A_DATA, 8'(i));
		pulse(10'h002, 4);
		chk_reg("count", A_COUNT, 8'h00);
		wait_out(2 * NB);
		for (int i = 0; i < NB; i++) chk("format byte", {2'h0, 8'(i)}, {2'h0, drv_u.rx[NB + i]});
		pulse(10'h001, 1);
		$display("format test done");
		wr(A_STATE, 8'h10);
		pulse(10'h020, 1022);
		chk_reg("fault", A_FAULT, 8'h00);
		pulse(10'h020, 1);
		pulse(10'h200, 1);
		chk_bit("skip", 1'b1, data_field_skip_o);
		pulse(10'h001, 1);
		chk_reg("fault", A_FAULT, 8'h82);
		seek_complete_i = 1'b0;
		chk_reg("status", A_STATE, 8'h41);
		$display("restore test done");
		final_report();
	end
endmodule : dtf_task_file_tb_top
